/* core/dom_defines.svh */
// Object indices, sub-indices, widths and reset values for the discrete output map.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DOM_DEFINES_SVH
`define DOM_DEFINES_SVH

`define DOM_CHANNELS        8
`define DOM_WORD_W          16
`define DOM_BYTE_W          8

`define DOM_IDX_OUT_BYTE    16'h6200
`define DOM_IDX_OUT_WORD    16'h6300
`define DOM_IDX_POLARITY    16'h6302
`define DOM_IDX_FB_MODE     16'h6306
`define DOM_IDX_FB_VALUE    16'h6307
`define DOM_IDX_MASK        16'h6308

`define DOM_SUB_COUNT       8'h00
`define DOM_SUB_FIRST       8'h01
`define DOM_SUB_SECOND      8'h02

`define DOM_BYTE_TBL_ENTRIES 16'h0002
`define DOM_WORD_TBL_ENTRIES 16'h0001

`define DOM_RST_OUT         8'h00
`define DOM_RST_POLARITY    8'h00
`define DOM_RST_FB_MODE     8'h00
`define DOM_RST_FB_VALUE    8'h00
`define DOM_RST_MASK        8'h00

`endif

/* core/dom_pkg.sv */
// Types shared by the discrete output map modules.
// Assumes nothing of its surroundings.
package dom_pkg;

  typedef enum logic [2:0] {
    OBJ_NONE,
    OBJ_OUT_BYTE,
    OBJ_OUT_WORD,
    OBJ_POLARITY,
    OBJ_FB_MODE,
    OBJ_FB_VALUE,
    OBJ_MASK
  } dom_obj_e;

  typedef enum logic [1:0] {
    SUB_COUNT,
    SUB_LOW,
    SUB_HIGH,
    SUB_BAD
  } dom_sub_e;

endpackage

/* core/dom_od_decode.sv */
// Object dictionary decoder: maps an index and sub-index onto an object and entry.
// Assumes index and sub-index are stable while the request is presented.
`timescale 1ns/1ps
`include "dom_defines.svh"

module dom_od_decode (
  // Request address
  input  wire logic [15:0]        odIndex,
  input  wire logic [7:0]         odSub,
  // Decoded object
  output dom_pkg::dom_obj_e       obj,
  output dom_pkg::dom_sub_e       sub
);

  always_comb begin
    case (odIndex)
      `DOM_IDX_OUT_BYTE: obj = dom_pkg::OBJ_OUT_BYTE;
      `DOM_IDX_OUT_WORD: obj = dom_pkg::OBJ_OUT_WORD;
      `DOM_IDX_POLARITY: obj = dom_pkg::OBJ_POLARITY;
      `DOM_IDX_FB_MODE:  obj = dom_pkg::OBJ_FB_MODE;
      `DOM_IDX_FB_VALUE: obj = dom_pkg::OBJ_FB_VALUE;
      `DOM_IDX_MASK:     obj = dom_pkg::OBJ_MASK;
      default:           obj = dom_pkg::OBJ_NONE;
    endcase
  end

  // Byte table has two entries, word tables one
  always_comb begin
    case (odSub)
      `DOM_SUB_COUNT:  sub = dom_pkg::SUB_COUNT;
      `DOM_SUB_FIRST:  sub = dom_pkg::SUB_LOW;
      `DOM_SUB_SECOND: sub = (obj == dom_pkg::OBJ_OUT_BYTE) ? dom_pkg::SUB_HIGH
                                                            : dom_pkg::SUB_BAD;
      default:         sub = dom_pkg::SUB_BAD;
    endcase
  end

endmodule // dom_od_decode

/* core/dom_chan_drive.sv */
// Per-channel physical output stage: masking, fallback, polarity and direction gating.
// Assumes all setting inputs come from registers in the same clock domain.
`timescale 1ns/1ps
`include "dom_defines.svh"

module dom_chan_drive #(
  parameter int CH = `DOM_CHANNELS
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Settings
  input  wire logic [CH-1:0] written,
  input  wire logic [CH-1:0] polarity,
  input  wire logic [CH-1:0] fbMode,
  input  wire logic [CH-1:0] fbValue,
  input  wire logic [CH-1:0] mask,
  input  wire logic [CH-1:0] dirOut,
  input  wire logic          commLost,
  // Physical drive
  output logic      [CH-1:0] chanOut,
  output logic      [CH-1:0] chanOe
);

  logic [CH-1:0] state_q;
  logic [CH-1:0] state_d;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      if (!dirOut[i]) begin
        state_d[i] = state_q[i]; // RQ2
      end else if (commLost) begin
        state_d[i] = fbMode[i] ? fbValue[i] : state_q[i]; // RQ13
      end else if (mask[i]) begin
        state_d[i] = state_q[i]; // RQ10
      end else begin
        state_d[i] = written[i]; // RQ1
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= `DOM_RST_OUT;
    end else begin
      state_q <= state_d;
    end
  end

  // Input channels are never driven
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chanOut <= '0;
      chanOe  <= '0;
    end else begin
      chanOut <= (state_d ^ polarity) & dirOut; // RQ12
      chanOe  <= dirOut; // RQ11
    end
  end

endmodule // dom_chan_drive

/* core/dom_top.sv */
// Discrete output object map: output table, polarity, fallback and masking objects.
// Assumes a one-request-at-a-time object dictionary access port and a direction input.
//
// Contract
// RQ1 - Byte table entry one bits 0..7 set output channels 0..7.
// RQ2 - Bits of input-configured channels are unassigned and have no effect; written bits are still stored and drive the channel once it turns output.
// RQ3 - Output word bits 0..7 drive channels; bits 8..15 carry nothing.
// RQ4 - All objects are 16-bit words except the byte-wide output table.
// RQ5 - Byte table entry one aliases the output word low byte.
// RQ6 - Byte table entry two aliases the word high byte, unassigned.
// RQ7 - One output polarity bit per channel in bits 0..7.
// RQ8 - One fallback mode bit per output channel in bits 0..7.
// RQ9 - One fallback value bit per output channel in bits 0..7.
// RQ10 - One output masking bit per output channel in bits 0..7.
// RQ11 - Per-channel direction bit selects input or output behaviour.
// RQ12 - Set polarity bit inverts the physical output.
// RQ13 - On communication loss fallback channels take fallback value, others hold.
`timescale 1ns/1ps
`include "dom_defines.svh"

module dom_top #(
  parameter int CH = `DOM_CHANNELS
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // Object dictionary access
  input  wire logic                    odReq,
  input  wire logic                    odWrite,
  input  wire logic [15:0]             odIndex,
  input  wire logic [7:0]              odSub,
  input  wire logic [`DOM_WORD_W-1:0]  odWdata,
  output logic      [`DOM_WORD_W-1:0]  odRdata,
  output logic                         odAck,
  output logic                         odErr,
  // Channel configuration and link state
  input  wire logic [CH-1:0]           chanDirOut,
  input  wire logic                    commLost,
  // Physical outputs and status
  output logic      [CH-1:0]           chanOut,
  output logic      [CH-1:0]           chanOe,
  output logic                         fallbackActive
);

  // Channel bits of a word, cleared for input channels
  function automatic logic [`DOM_WORD_W-1:0] assigned(
    input logic [CH-1:0] v,
    input logic [CH-1:0] dir
  );
    logic [`DOM_WORD_W-1:0] r;
    r = '0;
    r[CH-1:0] = v & dir;
    return r;
  endfunction

  // A write replaces every channel bit; the old value is ignored
  function automatic logic [CH-1:0] merged(
    input logic [CH-1:0] old,
    input logic [CH-1:0] wr
  );
    return wr;
  endfunction

  dom_pkg::dom_obj_e obj;
  dom_pkg::dom_sub_e sub;

  dom_od_decode u_decode (
    .odIndex (odIndex),
    .odSub   (odSub),
    .obj     (obj),
    .sub     (sub)
  );

  logic [CH-1:0] outWord_q;
  logic [CH-1:0] polarity_q;
  logic [CH-1:0] fbMode_q;
  logic [CH-1:0] fbValue_q;
  logic [CH-1:0] mask_q;

  logic [CH-1:0] wrBits;
  logic          entryWrite;
  logic          entryOk;
  logic          subCount;

  assign wrBits     = odWdata[CH-1:0];
  assign subCount   = (sub == dom_pkg::SUB_COUNT);
  assign entryOk    = (obj != dom_pkg::OBJ_NONE) && (sub != dom_pkg::SUB_BAD);
  // Entry counts are read only
  assign entryWrite = odReq && odWrite && entryOk && !subCount;

  // Both views store the same low byte; the high entry is dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outWord_q <= `DOM_RST_OUT;
    end else if (entryWrite && sub == dom_pkg::SUB_LOW &&
                 (obj == dom_pkg::OBJ_OUT_BYTE || obj == dom_pkg::OBJ_OUT_WORD)) begin
      outWord_q <= merged(outWord_q, wrBits); // RQ5
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polarity_q <= `DOM_RST_POLARITY;
    end else if (entryWrite && obj == dom_pkg::OBJ_POLARITY) begin
      polarity_q <= merged(polarity_q, wrBits); // RQ7
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fbMode_q <= `DOM_RST_FB_MODE;
    end else if (entryWrite && obj == dom_pkg::OBJ_FB_MODE) begin
      fbMode_q <= merged(fbMode_q, wrBits); // RQ8
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fbValue_q <= `DOM_RST_FB_VALUE;
    end else if (entryWrite && obj == dom_pkg::OBJ_FB_VALUE) begin
      fbValue_q <= merged(fbValue_q, wrBits); // RQ9
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= `DOM_RST_MASK;
    end else if (entryWrite && obj == dom_pkg::OBJ_MASK) begin
      mask_q <= merged(mask_q, wrBits); // RQ10
    end
  end

  // Read value of the addressed entry
  logic [`DOM_WORD_W-1:0] rdValue;

  always_comb begin
    rdValue = '0;
    if (subCount) begin
      rdValue = (obj == dom_pkg::OBJ_OUT_BYTE) ? `DOM_BYTE_TBL_ENTRIES
                                               : `DOM_WORD_TBL_ENTRIES; // RQ4
    end else begin
      case (obj)
        dom_pkg::OBJ_OUT_BYTE: begin
          // Byte entries sit in the low lanes only
          if (sub == dom_pkg::SUB_LOW) begin
            rdValue = assigned(outWord_q, chanDirOut) & 16'h00ff; // RQ4
          end else begin
            rdValue = '0; // RQ6
          end
        end
        dom_pkg::OBJ_OUT_WORD: rdValue = assigned(outWord_q, chanDirOut); // RQ3
        dom_pkg::OBJ_POLARITY: rdValue = assigned(polarity_q, chanDirOut); // RQ2
        dom_pkg::OBJ_FB_MODE:  rdValue = assigned(fbMode_q, chanDirOut);
        dom_pkg::OBJ_FB_VALUE: rdValue = assigned(fbValue_q, chanDirOut);
        dom_pkg::OBJ_MASK:     rdValue = assigned(mask_q, chanDirOut);
        default:               rdValue = '0;
      endcase
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      odAck <= 1'b0;
      odErr <= 1'b0;
    end else begin
      odAck <= odReq;
      odErr <= odReq && (!entryOk || (odWrite && subCount));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      odRdata <= '0;
    end else if (odReq && !odWrite && entryOk) begin
      odRdata <= rdValue;
    end else if (odReq) begin
      odRdata <= '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fallbackActive <= 1'b0;
    end else begin
      fallbackActive <= commLost; // RQ13
    end
  end

  dom_chan_drive #(
    .CH (CH)
  ) u_drive (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .written  (outWord_q),
    .polarity (polarity_q),
    .fbMode   (fbMode_q),
    .fbValue  (fbValue_q),
    .mask     (mask_q),
    .dirOut   (chanDirOut),
    .commLost (commLost),
    .chanOut  (chanOut),
    .chanOe   (chanOe)
  );

endmodule // dom_top

/* tb/dom_master_model.sv */
// Network master model: issues one object access per call.
// Assumes the bench makes calls one at a time on sys_clk.
`timescale 1ns/1ps

module dom_master_model (
  // Clock
  input  wire logic   sys_clk,
  // Access port
  output logic        odReq   = 1'b0,
  output logic        odWrite = 1'b0,
  output logic [15:0] odIndex = 16'h0000,
  output logic [7:0]  odSub   = 8'h00,
  output logic [15:0] odWdata = 16'h0000
);
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic [15:0] d);
    @(posedge sys_clk);
    odReq   <= 1'b1;
    odWrite <= w;
    odIndex <= i;
    odSub   <= s;
    odWdata <= d;
    @(posedge sys_clk);
    odReq   <= 1'b0;
    // Stale data never lingers
    odWdata <= ~d;
  endtask
endmodule // dom_master_model

/* tb/dom_top_properties.sv */
// Port-level checker for the discrete output map.
// Assumes binding onto dom_top.
`timescale 1ns/1ps
`include "dom_defines.svh"

module dom_top_checker #(
  parameter int CH = 8
) (
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          rst,
  // Access port
  input wire logic          odReq,
  input wire logic          odWrite,
  input wire logic [15:0]   odIndex,
  input wire logic [7:0]    odSub,
  input wire logic [15:0]   odWdata,
  input wire logic [15:0]   odRdata,
  input wire logic          odAck,
  input wire logic          odErr,
  // Channels
  input wire logic [CH-1:0] chanDirOut,
  input wire logic          commLost,
  input wire logic [CH-1:0] chanOut,
  input wire logic [CH-1:0] chanOe,
  input wire logic          fallbackActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ACK_NEXT: assert property (odReq |=> odAck)
    else $error("No answer after request");
  AST_ACK_ONLY: assert property (!odReq |=> !odAck)
    else $error("Answer without request");
  AST_ERR_ACK: assert property (odErr |-> odAck)
    else $error("Error without answer");
  AST_BAD_IDX: assert property (odReq && !(odIndex inside {`DOM_IDX_OUT_BYTE,
    `DOM_IDX_OUT_WORD, `DOM_IDX_POLARITY, `DOM_IDX_FB_MODE, `DOM_IDX_FB_VALUE,
    `DOM_IDX_MASK}) |=> odErr) else $error("Unknown object accepted");
  AST_WORD_WR: assert property (odReq && odWrite && odIndex == `DOM_IDX_OUT_WORD
    && odSub == 8'h01 |=> !odErr) else $error("Word write refused");
  AST_RD_HIGH: assert property (odReq && !odWrite && odIndex == `DOM_IDX_OUT_WORD
    |=> odRdata[15:8] == 8'h00) else $error("Word high byte not zero");
  AST_SUB2: assert property (odReq && odIndex == `DOM_IDX_OUT_BYTE && odSub == 8'h02
    |=> !odErr && odRdata == 16'h0000) else $error("Second byte entry wrong");
  AST_IN_LOW: assert property ((chanOut & ~chanOe) == '0)
    else $error("Input channel driven");
  AST_OE_DIR: assert property (!rst |=> chanOe == $past(chanDirOut))
    else $error("Enable does not follow direction");
  AST_FB_FLAG: assert property (!rst |=> fallbackActive == $past(commLost))
    else $error("Fallback flag wrong");
  AST_HOLD: assert property ((!odReq && !commLost && $stable(chanDirOut)) [*2]
    |=> $stable(chanOut)) else $error("Output moved without cause");
endmodule // dom_top_checker

bind dom_top dom_top_checker #(.CH(CH)) u_chk (.sys_clk, .rst, .odReq, .odWrite,
  .odIndex, .odSub, .odWdata, .odRdata, .odAck, .odErr, .chanDirOut, .commLost,
  .chanOut, .chanOe, .fallbackActive);

/* tb/dom_top_tb_top.sv */
// Self-checking bench for the discrete output map.
// Assumes dom_top, its checker and the master model are compiled first.
`timescale 1ns/1ps
`include "dom_defines.svh"

module dom_top_tb_top;
  localparam logic [15:0] OB = `DOM_IDX_OUT_BYTE;
  localparam logic [15:0] OW = `DOM_IDX_OUT_WORD;
  localparam logic [15:0] PO = `DOM_IDX_POLARITY;
  localparam logic [15:0] FM = `DOM_IDX_FB_MODE;
  localparam logic [15:0] FV = `DOM_IDX_FB_VALUE;
  localparam logic [15:0] MK = `DOM_IDX_MASK;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        odReq, odWrite, odAck, odErr, fallbackActive;
  logic [15:0] odIndex, odWdata, odRdata;
  logic [7:0]  odSub, chanOut, chanOe;
  logic [7:0]  chanDirOut = 8'hff;
  logic        commLost = 1'b0;
  logic [15:0] idx [4] = '{PO, FM, FV, MK};
  int          num_errors = 0;
  int          samples_checked = 0;

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  dom_master_model m (.sys_clk, .odReq, .odWrite, .odIndex, .odSub, .odWdata);
  dom_top dut (.sys_clk, .rst, .odReq, .odWrite, .odIndex, .odSub, .odWdata,
    .odRdata, .odAck, .odErr, .chanDirOut, .commLost, .chanOut, .chanOe,
    .fallbackActive);

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_ans(input logic e, input logic [15:0] x);
    samples_checked++;
    if (odAck !== 1'b1 || odErr !== e || odRdata !== x) begin
      num_errors++;
      $display("[FAIL] %0t answer err=%b data=%h", $time, odErr, odRdata);
    end
  endtask

  // Outputs settle one edge after the access completes; pins are checked after two edges
  task automatic chk_pins(input logic [7:0] x, input logic f);
    repeat (2) @(posedge sys_clk);
    #1;
    samples_checked++;
    if (chanOut !== x || fallbackActive !== f || chanOe !== chanDirOut) begin
      num_errors++;
      $display("[FAIL] %0t pins out=%h fb=%b", $time, chanOut, fallbackActive);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [15:0] d, input logic e, input logic [15:0] x);
    m.xfer(w, i, s, d);
    #1;
    chk_ans(e, x);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d);
    acc(1'b1, i, s, d, 1'b0, 16'h0000);
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [15:0] x);
    acc(1'b0, i, s, 16'h0000, 1'b0, x);
  endtask

  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    chk_pins(8'h00, 1'b0);
    wr(OW, 8'h01, 16'ha5a5);
    chk_pins(8'ha5, 1'b0);
    rd(OW, 8'h01, 16'h00a5);
    rd(OB, 8'h01, 16'h00a5);
    wr(OB, 8'h01, 16'h003c);
    rd(OW, 8'h01, 16'h003c);
    chk_pins(8'h3c, 1'b0);
    wr(OB, 8'h02, 16'h00ff);
    rd(OB, 8'h02, 16'h0000);
    rd(OB, 8'h00, 16'h0002);
    rd(OW, 8'h00, 16'h0001);
    acc(1'b1, OW, 8'h00, 16'h0001, 1'b1, 16'h0000);
    acc(1'b0, OW, 8'h02, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 16'h6301, 8'h01, 16'h0000, 1'b1, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(idx[k], 8'h01, 16'habcd);
      rd(idx[k], 8'h01, 16'h00cd);
      wr(idx[k], 8'h01, 16'h0000);
    end
    wr(PO, 8'h01, 16'h000f);
    chk_pins(8'h33, 1'b0);
    wr(PO, 8'h01, 16'h0000);
    wr(MK, 8'h01, 16'h0001);
    wr(OW, 8'h01, 16'h00ff);
    chk_pins(8'hfe, 1'b0);
    wr(MK, 8'h01, 16'h0000);
    wr(OW, 8'h01, 16'h003c);
    wr(FM, 8'h01, 16'h000f);
    wr(FV, 8'h01, 16'h0005);
    @(posedge sys_clk);
    commLost <= 1'b1;
    chk_pins(8'h35, 1'b1);
    wr(OW, 8'h01, 16'h00c3);
    chk_pins(8'h35, 1'b1);
    @(posedge sys_clk);
    commLost <= 1'b0;
    chk_pins(8'hc3, 1'b0);
    @(posedge sys_clk);
    chanDirOut <= 8'hf0;
    chk_pins(8'hc0, 1'b0);
    rd(OW, 8'h01, 16'h00c0);
    wr(OW, 8'h01, 16'h000f);
    chk_pins(8'h00, 1'b0);
    wr(PO, 8'h01, 16'h000f);
    chk_pins(8'h00, 1'b0);
    rd(PO, 8'h01, 16'h0000);
    wr(PO, 8'h01, 16'h0000);
    @(posedge sys_clk);
    chanDirOut <= 8'hff;
    chk_pins(8'h0f, 1'b0);
    close_out();
  end
endmodule // dom_top_tb_top
